// file: core/sld_pkg.sv
// Purpose: shared constants and types of the synthesizer power-down and lock-detect control
// Assumes: phase error arrives as an unsigned count of 1 ns steps per comparison cycle
// Notes: register offsets are byte addresses on a 32-bit classic Wishbone slave
package sld_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // phase error and lock windows
  localparam int ERR_W = 8;
  localparam int PHASE_LSB_NS = 1;
  localparam int EPS_MAIN_NS = 10;
  localparam int EPS_AUX_NS = 15;
  localparam int DLT_MAIN_NS = 20;
  localparam int DLT_AUX_NS = 30;
  localparam logic [ERR_W-1:0] WIN_LOCK_MAIN = ERR_W'(EPS_MAIN_NS / PHASE_LSB_NS);
  localparam logic [ERR_W-1:0] WIN_LOCK_AUX = ERR_W'(EPS_AUX_NS / PHASE_LSB_NS);
  localparam logic [ERR_W-1:0] WIN_LOSS_MAIN = ERR_W'(DLT_MAIN_NS / PHASE_LSB_NS);
  localparam logic [ERR_W-1:0] WIN_LOSS_AUX = ERR_W'(DLT_AUX_NS / PHASE_LSB_NS);
  localparam logic [2:0] LD_CONSEC = 3'h5;
  localparam logic [1:0] QRATE_LAST = 2'h3;
  ////////////////////////////////////////////////////////////////////////////////
  // test pin views and slip reduction factors
  localparam logic [3:0] TSEL_LOW = 4'h0;
  localparam logic [3:0] TSEL_MAIN = 4'h1;
  localparam logic [3:0] TSEL_AUX = 4'h2;
  localparam logic [3:0] TSEL_BOTH = 4'h3;
  localparam logic [1:0] SLIP_HALF = 2'h0;
  localparam logic [1:0] SLIP_QUARTER = 2'h1;
  localparam logic [1:0] SLIP_SIXTEENTH = 2'h2;
  localparam logic [3:0] SKIP_HALF = 4'h1;
  localparam logic [3:0] SKIP_QUARTER = 4'h3;
  localparam logic [3:0] SKIP_SIXTEENTH = 4'hf;
  ////////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] OFS_DIV = 8'h04;
  localparam logic [ADR_W-1:0] OFS_TMO = 8'h08;
  localparam logic [ADR_W-1:0] OFS_STAT = 8'h0c;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [15:0] TMO_RST = 16'h0040;
  ////////////////////////////////////////////////////////////////////////////////
  // synchroniser lanes
  localparam int SYN_CE = 0;
  localparam int SYN_MTICK = 1;
  localparam int SYN_ATICK = 2;
  localparam int SYN_N = 3;
  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic wide_en;
    logic slip_en;
    logic [1:0] slip_sel;
    logic [3:0] test_pin_select_field;
    logic lock_detect_quarter_rate;
    logic auto_powerup_on_divider_write;
    logic aux_loop_powerdown_bit;
    logic main_loop_powerdown_bit;
  } sld_ctrl_t;
  localparam sld_ctrl_t CTRL_RST = 12'h000;
  typedef struct packed {
    logic wide_engaged;
    logic slip_engaged;
    logic aux_powered;
    logic main_powered;
    logic aux_locked;
    logic main_locked;
  } sld_stat_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADR_W-1:0] adr;
    logic [31:0] dat;
  } sld_wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } sld_wb_rsp_t;
  typedef enum logic [1:0] {ACQ_IDLE, ACQ_SLIP, ACQ_WIDE} sld_acq_t;
endpackage : sld_pkg

// file: core/sld_lock_det.sv
// Purpose: digital lock detector of one loop, narrow window to lock, wide window to lose it
// Assumes: tick is a one-cycle pulse per (possibly divided) comparison cycle, err valid with it
// Notes: clr empties the detector at once
`timescale 1ns/1ns
module sld_lock_det
  import sld_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // comparison input
  input wire logic clr,
  input wire logic tick,
  input wire logic [sld_pkg::ERR_W-1:0] err,
  input wire logic [sld_pkg::ERR_W-1:0] win_lock,
  input wire logic [sld_pkg::ERR_W-1:0] win_loss,
  // result
  output logic locked
);
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic lock_reg;
  logic lock_next;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    cnt_next = cnt_reg;
    lock_next = lock_reg;
    if (clr)
    begin
      cnt_next = 3'h0;
      lock_next = 1'b0;
    end
    else if (tick && !lock_reg)
    begin
      if (err < win_lock)
      begin
        if (cnt_reg == LD_CONSEC - 3'h1)
        begin
          lock_next = 1'b1;
          cnt_next = 3'h0;
        end
        else
        begin
          cnt_next = cnt_reg + 3'h1;
        end
      end
      else
      begin
        cnt_next = 3'h0;
      end
    end
    else if (tick && (err > win_loss))
    begin
      lock_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_reg <= 3'h0;
      lock_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      lock_reg <= lock_next;
    end
  end

  assign locked = lock_reg;

  ////////////////////////////////////////////////////////////////////////////////
  lock_after_five_a : assert property (@(posedge clk_sys) disable iff (rst)
    $rose(lock_reg) |-> $past(cnt_reg) == LD_CONSEC - 3'h1 && $past(tick)
      && $past(err) < $past(win_lock))
    else $error("lock rose without five in-window cycles");
  loss_wide_window_a : assert property (@(posedge clk_sys) disable iff (rst)
    $fell(lock_reg) |-> $past(clr) || ($past(tick) && $past(err) > $past(win_loss)))
    else $error("lock dropped without error beyond wide window");
  count_cleared_a : assert property (@(posedge clk_sys) disable iff (rst)
    !clr && tick && !lock_reg && err >= win_lock |=> cnt_reg == 3'h0 && !lock_reg)
    else $error("out-of-window cycle did not clear the count");
endmodule : sld_lock_det

// file: core/sld_top.sv
// Purpose: power-down arbitration, lock detect, slip reduction and wide-bandwidth acquisition
// Assumes: comparison tick pins are slow pulses held several clk_sys cycles, error words stable
// Notes: power state outputs follow the chip enable pin combinationally
//
// Summary of operation
// - chip enable low powers everything down asynchronously
// - enable high, bits clear: fully powered
// - power-down bit drops only its loop
// - auto power-up on divider write overrides main
// - lock after five cycles inside narrow window
// - locked: unlock only beyond wide window, on divider write or with loop off
// - test pin low while shown loop off
// - quarter-rate setting divides detector rate by four
// - combined view low if either unlocked
// - slip factors one half, quarter, sixteenth
// - slip lowers comparison rate, then reverts
// - wide bandwidth: fast current, parallel resistor
// - divider write engages aids, timeout counter releases them
// - divider write reinitialises detector and aid counters
`timescale 1ns/1ns
module sld_top
  import sld_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register bus
  input wire sld_pkg::sld_wb_req_t wb_req,
  output sld_pkg::sld_wb_rsp_t wb_rsp,
  // pins from the analog side
  input wire logic ce_pin,
  input wire logic main_cmp_tick_pin,
  input wire logic aux_cmp_tick_pin,
  input wire logic [sld_pkg::ERR_W-1:0] main_err_pin,
  input wire logic [sld_pkg::ERR_W-1:0] aux_err_pin,
  // power and loop controls
  output logic main_powered_out,
  output logic aux_powered_out,
  output logic main_pd_gate_out,
  output logic cp_fast_out,
  output logic loop_res_en_out,
  output logic test_lock_pin
);
  import sld_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [SYN_N-1:0] syn_in;
  logic [SYN_N-1:0] s1_reg;
  logic [SYN_N-1:0] s2_reg;
  logic [SYN_N-1:0] s3_reg;
  logic [SYN_N-1:0] filt_reg;
  logic [SYN_N-1:0] filt_next;
  logic [SYN_N-1:0] prev_reg;

  assign syn_in = {aux_cmp_tick_pin, main_cmp_tick_pin, ce_pin};

  genvar gi;
  generate
    for (gi = 0; gi < SYN_N; gi++)
    begin : g_sync
      always_comb
      begin
        filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s2_reg[gi] : filt_reg[gi];
      end
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          s1_reg[gi] <= 1'b0;
          s2_reg[gi] <= 1'b0;
          s3_reg[gi] <= 1'b0;
          filt_reg[gi] <= 1'b0;
          prev_reg[gi] <= 1'b0;
        end
        else
        begin
          s1_reg[gi] <= syn_in[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          filt_reg[gi] <= filt_next[gi];
          prev_reg[gi] <= filt_reg[gi];
        end
      end
    end
  endgenerate

  logic ce_f;
  logic [1:0] tick_rise;
  assign ce_f = filt_reg[SYN_CE];
  assign tick_rise[0] = filt_reg[SYN_MTICK] & ~prev_reg[SYN_MTICK];
  assign tick_rise[1] = filt_reg[SYN_ATICK] & ~prev_reg[SYN_ATICK];

  ////////////////////////////////////////////////////////////////////////////////
  // wishbone slave and registers
  sld_ctrl_t ctrl_reg;
  sld_ctrl_t ctrl_next;
  logic [15:0] div_reg;
  logic [15:0] div_next;
  logic [15:0] tmo_reg;
  logic [15:0] tmo_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic div_wr_reg;
  logic div_wr_next;
  logic autopu_reg;
  logic autopu_next;
  sld_stat_t stat;
  logic [1:0] locked;
  sld_acq_t acq_reg;

  function automatic logic [31:0] sld_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : sld_merge

  logic bus_req;
  logic bus_wr;
  assign bus_req = wb_req.cyc & wb_req.stb & ~ack_reg;
  // writes commit on the edge that sees ack high
  assign bus_wr = wb_req.cyc & wb_req.stb & wb_req.we & ack_reg;

  logic [31:0] ctrl_mrg;
  logic [31:0] div_mrg;
  logic [31:0] tmo_mrg;
  assign ctrl_mrg = sld_merge({20'h00000, ctrl_reg}, wb_req.dat, wb_req.sel);
  assign div_mrg = sld_merge({16'h0000, div_reg}, wb_req.dat, wb_req.sel);
  assign tmo_mrg = sld_merge({16'h0000, tmo_reg}, wb_req.dat, wb_req.sel);

  always_comb
  begin
    ctrl_next = ctrl_reg;
    div_next = div_reg;
    tmo_next = tmo_reg;
    ack_next = bus_req;
    rdat_next = 32'h0000_0000;
    div_wr_next = 1'b0;
    autopu_next = autopu_reg;
    if (bus_req || bus_wr)
    begin
      unique case (wb_req.adr)
        OFS_CTRL:
        begin
          rdat_next = {20'h00000, ctrl_reg};
          if (bus_wr)
          begin
            ctrl_next = sld_ctrl_t'(ctrl_mrg[11:0]);
          end
        end
        OFS_DIV:
        begin
          rdat_next = {16'h0000, div_reg};
          if (bus_wr)
          begin
            div_next = div_mrg[15:0];
            div_wr_next = 1'b1;
          end
        end
        OFS_TMO:
        begin
          rdat_next = {16'h0000, tmo_reg};
          if (bus_wr)
          begin
            tmo_next = tmo_mrg[15:0];
          end
        end
        OFS_STAT:
        begin
          rdat_next = {26'h0, stat};
        end
        default:
        begin
          rdat_next = 32'h0000_0000;
        end
      endcase
    end
    // override latch: set on divider write, dropped by enable low or re-asserted power-down
    if (!ce_f)
    begin
      autopu_next = 1'b0;
    end
    else if (bus_wr && wb_req.adr == OFS_DIV && ctrl_reg.auto_powerup_on_divider_write)
    begin
      autopu_next = 1'b1;
    end
    else if (bus_wr && wb_req.adr == OFS_CTRL && ctrl_next.main_loop_powerdown_bit
             && !ctrl_reg.main_loop_powerdown_bit)
    begin
      autopu_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RST;
      div_reg <= DIV_RST;
      tmo_reg <= TMO_RST;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
      div_wr_reg <= 1'b0;
      autopu_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      div_reg <= div_next;
      tmo_reg <= tmo_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      div_wr_reg <= div_wr_next;
      autopu_reg <= autopu_next;
    end
  end

  assign wb_rsp.ack = ack_reg;
  assign wb_rsp.dat = rdat_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // power arbitration
  logic main_on;
  logic aux_on;
  // raw pin keeps power-down asynchronous
  assign main_powered_out = ce_pin & (~ctrl_reg.main_loop_powerdown_bit | autopu_reg);
  assign aux_powered_out = ce_pin & ~ctrl_reg.aux_loop_powerdown_bit;
  assign main_on = ce_f & (~ctrl_reg.main_loop_powerdown_bit | autopu_reg);
  assign aux_on = ce_f & ~ctrl_reg.aux_loop_powerdown_bit;

  ////////////////////////////////////////////////////////////////////////////////
  // lock detectors with optional quarter rate
  logic [1:0] qcnt_reg [2];
  logic [1:0] qcnt_next [2];
  logic [1:0] ld_tick;
  logic [1:0] loop_on;
  logic [ERR_W-1:0] ld_err [2];
  logic [ERR_W-1:0] ld_win_lock [2];
  logic [ERR_W-1:0] ld_win_loss [2];
  logic tpin_reg;
  logic tpin_next;

  assign loop_on = {aux_on, main_on};
  assign ld_err[0] = main_err_pin;
  assign ld_err[1] = aux_err_pin;
  assign ld_win_lock[0] = WIN_LOCK_MAIN;
  assign ld_win_lock[1] = WIN_LOCK_AUX;
  assign ld_win_loss[0] = WIN_LOSS_MAIN;
  assign ld_win_loss[1] = WIN_LOSS_AUX;

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ld
      assign ld_tick[gi] = tick_rise[gi] & (~ctrl_reg.lock_detect_quarter_rate
                                            | qcnt_reg[gi] == QRATE_LAST);
      always_comb
      begin
        qcnt_next[gi] = qcnt_reg[gi];
        if (div_wr_reg || !ctrl_reg.lock_detect_quarter_rate)
        begin
          qcnt_next[gi] = 2'h0;
        end
        else if (tick_rise[gi])
        begin
          qcnt_next[gi] = qcnt_reg[gi] + 2'h1;
        end
      end
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          qcnt_reg[gi] <= 2'h0;
        end
        else
        begin
          qcnt_reg[gi] <= qcnt_next[gi];
        end
      end
      sld_lock_det sld_lock_det_inst (
        .clk_sys(clk_sys),
        .rst(rst),
        .clr(div_wr_reg | ~loop_on[gi]),
        .tick(ld_tick[gi]),
        .err(ld_err[gi]),
        .win_lock(ld_win_lock[gi]),
        .win_loss(ld_win_loss[gi]),
        .locked(locked[gi])
      );
    end
  endgenerate

  // test pin view, gated low at once by power-down of the shown loop
  logic tpin_gate;
  always_comb
  begin
    tpin_next = 1'b0;
    tpin_gate = 1'b1;
    unique case (ctrl_reg.test_pin_select_field)
      TSEL_MAIN:
      begin
        tpin_next = locked[0];
        tpin_gate = main_powered_out;
      end
      TSEL_AUX:
      begin
        tpin_next = locked[1];
        tpin_gate = aux_powered_out;
      end
      TSEL_BOTH:
      begin
        tpin_next = locked[0] & locked[1];
        tpin_gate = main_powered_out & aux_powered_out;
      end
      default:
      begin
        tpin_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tpin_reg <= 1'b0;
    end
    else
    begin
      tpin_reg <= tpin_next;
    end
  end

  assign test_lock_pin = tpin_reg & tpin_gate;

  ////////////////////////////////////////////////////////////////////////////////
  // acquisition aids and timeout
  sld_acq_t acq_next;
  logic [15:0] tmo_cnt_reg;
  logic [15:0] tmo_cnt_next;
  logic [3:0] skip_reg;
  logic [3:0] skip_next;
  logic [3:0] skip_max;
  logic gate_reg;
  logic gate_next;
  logic slip_ok;

  always_comb
  begin
    slip_ok = 1'b1;
    unique case (ctrl_reg.slip_sel)
      SLIP_HALF: skip_max = SKIP_HALF;
      SLIP_QUARTER: skip_max = SKIP_QUARTER;
      SLIP_SIXTEENTH: skip_max = SKIP_SIXTEENTH;
      default:
      begin
        skip_max = SKIP_HALF;
        slip_ok = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    acq_next = acq_reg;
    tmo_cnt_next = tmo_cnt_reg;
    skip_next = skip_reg;
    gate_next = tick_rise[0] & main_on & (acq_reg != ACQ_SLIP || skip_reg == 4'h0);
    if (!main_on)
    begin
      acq_next = ACQ_IDLE;
    end
    else if (div_wr_reg)
    begin
      tmo_cnt_next = 16'h0000;
      skip_next = 4'h0;
      if (ctrl_reg.slip_en && slip_ok)
      begin
        acq_next = ACQ_SLIP;
      end
      else if (ctrl_reg.wide_en)
      begin
        acq_next = ACQ_WIDE;
      end
      else
      begin
        acq_next = ACQ_IDLE;
      end
    end
    else if (acq_reg != ACQ_IDLE && tick_rise[0])
    begin
      skip_next = (skip_reg == skip_max) ? 4'h0 : skip_reg + 4'h1;
      tmo_cnt_next = tmo_cnt_reg + 16'h0001;
      if (tmo_cnt_reg >= tmo_reg)
      begin
        acq_next = ACQ_IDLE;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      acq_reg <= ACQ_IDLE;
      tmo_cnt_reg <= 16'h0000;
      skip_reg <= 4'h0;
      gate_reg <= 1'b0;
    end
    else
    begin
      acq_reg <= acq_next;
      tmo_cnt_reg <= tmo_cnt_next;
      skip_reg <= skip_next;
      gate_reg <= gate_next;
    end
  end

  assign main_pd_gate_out = gate_reg;
  assign cp_fast_out = acq_reg != ACQ_IDLE;
  assign loop_res_en_out = acq_reg == ACQ_WIDE;
  assign stat = '{wide_engaged: acq_reg == ACQ_WIDE, slip_engaged: acq_reg == ACQ_SLIP,
                  aux_powered: aux_powered_out, main_powered: main_powered_out,
                  aux_locked: locked[1], main_locked: locked[0]};

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  ce_powerdown_a : assert property (!ce_pin |-> !main_powered_out && !aux_powered_out)
    else $error("powered while chip enable low");
  full_powerup_a : assert property (ce_pin && ctrl_reg[1:0] == 2'h0
    |-> main_powered_out && aux_powered_out)
    else $error("not fully powered with bits clear");
  auto_powerup_a : assert property (ce_f && ce_pin && bus_wr && wb_req.adr == OFS_DIV
    && ctrl_reg.auto_powerup_on_divider_write ##1 ce_pin && ce_f |-> main_powered_out)
    else $error("divider write did not power main loop");
  pin_forced_low_a : assert property (ctrl_reg.test_pin_select_field == TSEL_MAIN
    && !main_powered_out |-> !test_lock_pin)
    else $error("test pin high while main loop off");
  combined_view_a : assert property (ctrl_reg.test_pin_select_field == TSEL_BOTH
    && $stable(ctrl_reg) && !$past(locked[0] && locked[1]) |-> !test_lock_pin)
    else $error("combined view high with a loop unlocked");
  quarter_rate_a : assert property (ctrl_reg.lock_detect_quarter_rate && ld_tick[0]
    |=> !ld_tick[0] [*3])
    else $error("quarter rate ticks too close");
  resistor_wide_only_a : assert property ($rose(loop_res_en_out) |-> $past(div_wr_reg)
    && cp_fast_out && ctrl_reg.wide_en)
    else $error("parallel resistor outside wide acquisition");
  reinit_count_a : assert property (div_wr_reg && main_on |=> tmo_cnt_reg == 16'h0000
    && skip_reg == 4'h0)
    else $error("divider write did not reset aid counters");
  timeout_release_a : assert property (main_on && !div_wr_reg && acq_reg != ACQ_IDLE
    && tick_rise[0] && tmo_cnt_reg >= tmo_reg |=> acq_reg == ACQ_IDLE)
    else $error("aid not released at timeout");
  slip_skip_a : assert property (acq_reg == ACQ_SLIP && skip_reg != 4'h0
    |=> !main_pd_gate_out)
    else $error("comparison passed during skipped slip cycle");
endmodule : sld_top

// file: verification/sld_top_tb.sv
// Purpose: self-checking bench of the power-down and lock-detect control
// Assumes: tick pins held five cycles high and low, error words steady between ticks
// Notes: in-window errors drawn at random, boundary errors written by hand
`timescale 1ns/1ns
module sld_top_tb;
  import sld_pkg::*;
  localparam int LIMIT = 10000;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  sld_wb_req_t wb_req = '0;
  sld_wb_rsp_t wb_rsp;
  logic ce_pin = 1'b1;
  logic main_cmp_tick_pin = 1'b0;
  logic aux_cmp_tick_pin = 1'b0;
  logic [ERR_W-1:0] main_err_pin = '0;
  logic [ERR_W-1:0] aux_err_pin = '0;
  logic main_powered_out, aux_powered_out, main_pd_gate_out;
  logic cp_fast_out, loop_res_en_out, test_lock_pin;
  logic [31:0] rdv;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int gates = 0;

  always #5 clk_sys = ~clk_sys;

  sld_top sld_top_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .wb_req(wb_req),
    .wb_rsp(wb_rsp),
    .ce_pin(ce_pin),
    .main_cmp_tick_pin(main_cmp_tick_pin),
    .aux_cmp_tick_pin(aux_cmp_tick_pin),
    .main_err_pin(main_err_pin),
    .aux_err_pin(aux_err_pin),
    .main_powered_out(main_powered_out),
    .aux_powered_out(aux_powered_out),
    .main_pd_gate_out(main_pd_gate_out),
    .cp_fast_out(cp_fast_out),
    .loop_res_en_out(loop_res_en_out),
    .test_lock_pin(test_lock_pin)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // gate pulse counter and hang guard
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (main_pd_gate_out === 1'b1)
      gates <= gates + 1;
    if (cycles == LIMIT)
    begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] stat_v(input logic ml, al, mp, ap);
    return {28'h0, ap, mp, al, ml};
  endfunction : stat_v

  function automatic int exp_gates(input int s);
    return (s == 0) ? 8 : ((s == 1) ? 4 : 1);
  endfunction : exp_gates

  // one classic cycle, then a few idle edges so effects have landed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hf, adr: a, dat: d};
    @(posedge clk_sys);
    while (wb_rsp.ack !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    rdv = wb_rsp.dat;
    wb_req <= '0;
    repeat (3) @(posedge clk_sys);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rdc

  task automatic tk(input logic m, input int e);
    if (m)
    begin
      main_err_pin <= 8'(e);
      main_cmp_tick_pin <= 1'b1;
    end
    else
    begin
      aux_err_pin <= 8'(e);
      aux_cmp_tick_pin <= 1'b1;
    end
    repeat (5) @(posedge clk_sys);
    main_cmp_tick_pin <= 1'b0;
    aux_cmp_tick_pin <= 1'b0;
    repeat (5) @(posedge clk_sys);
  endtask : tk

  task automatic good(input logic m, input int n);
    repeat (n) tk(m, m ? $urandom_range(9) : $urandom_range(14));
  endtask : good

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(41));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_DIV, 32'h0);
    rdc(OFS_TMO, {16'h0, TMO_RST});
    wr(8'h10, 32'hfff);
    rdc(8'h10, 32'h0);
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_STAT, stat_v(0, 0, 1, 1));
    wr(OFS_CTRL, 32'h10);
    good(1, 4);
    tk(1, 10);
    good(1, 4);
    rdc(OFS_STAT, stat_v(0, 0, 1, 1));
    good(1, 1);
    rdc(OFS_STAT, stat_v(1, 0, 1, 1));
    chk(test_lock_pin, 1'b1);
    tk(1, 20);
    rdc(OFS_STAT, stat_v(1, 0, 1, 1));
    tk(1, 21);
    rdc(OFS_STAT, stat_v(0, 0, 1, 1));
    chk(test_lock_pin, 1'b0);
    wr(OFS_CTRL, 32'h30);
    good(1, 5);
    repeat (5) tk(0, 14);
    tk(0, 30);
    rdc(OFS_STAT, stat_v(1, 1, 1, 1));
    chk(test_lock_pin, 1'b1);
    tk(0, 31);
    rdc(OFS_STAT, stat_v(1, 0, 1, 1));
    chk(test_lock_pin, 1'b0);
    wr(OFS_DIV, 32'h1234);
    rdc(OFS_STAT, stat_v(0, 0, 1, 1));
    wr(OFS_CTRL, 32'h10);
    good(1, 5);
    chk(test_lock_pin, 1'b1);
    wr(OFS_CTRL, 32'h11);
    chk(test_lock_pin, 1'b0);
    chk(main_powered_out, 1'b0);
    chk(aux_powered_out, 1'b1);
    wr(OFS_CTRL, 32'h20);
    good(0, 5);
    chk(test_lock_pin, 1'b1);
    wr(OFS_CTRL, 32'h22);
    chk(test_lock_pin, 1'b0);
    chk(aux_powered_out, 1'b0);
    rdc(OFS_STAT, stat_v(0, 0, 1, 0));
    wr(OFS_CTRL, 32'h5);
    chk(main_powered_out, 1'b0);
    wr(OFS_DIV, 32'h2);
    chk(main_powered_out, 1'b1);
    ce_pin <= 1'b0;
    @(negedge clk_sys);
    chk(main_powered_out, 1'b0);
    chk(aux_powered_out, 1'b0);
    @(posedge clk_sys);
    wr(OFS_DIV, 32'h2);
    chk(main_powered_out, 1'b0);
    ce_pin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk(main_powered_out, 1'b0);
    chk(aux_powered_out, 1'b1);
    wr(OFS_CTRL, 32'h8);
    chk(main_powered_out, 1'b1);
    wr(OFS_DIV, 32'h3);
    good(1, 16);
    rdc(OFS_STAT, stat_v(0, 0, 1, 1));
    good(1, 4);
    rdc(OFS_STAT, stat_v(1, 0, 1, 1));
    wr(OFS_TMO, 32'h10);
    for (int s = 0; s < 3; s++)
    begin
      wr(OFS_CTRL, 32'h400 | (s << 8));
      wr(OFS_DIV, 32'h4);
      gates = 0;
      chk(cp_fast_out, 1'b1);
      chk(loop_res_en_out, 1'b0);
      good(1, 16);
      chk(gates, exp_gates(s));
      chk(cp_fast_out, 1'b1);
      good(1, 1);
      chk(cp_fast_out, 1'b0);
    end
    wr(OFS_CTRL, 32'h700);
    wr(OFS_DIV, 32'h5);
    chk(cp_fast_out, 1'b0);
    wr(OFS_TMO, 32'h3);
    wr(OFS_CTRL, 32'h800);
    wr(OFS_DIV, 32'h6);
    gates = 0;
    chk(cp_fast_out, 1'b1);
    chk(loop_res_en_out, 1'b1);
    good(1, 3);
    chk(gates, 32'h3);
    chk(loop_res_en_out, 1'b1);
    good(1, 1);
    chk(loop_res_en_out, 1'b0);
    chk(cp_fast_out, 1'b0);
    close_out();
  end
endmodule : sld_top_tb
